// ==== design/ptt_pkg.sv ====
// Constants and state types for the periodic tick timer
package ptt_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int CNT_W  = 24;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int IDX_W  = 3;
  localparam int IRQ_W  = 1;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] OFS_ISTS   = 32'h0000_000c;
  localparam logic [ADDR_W-1:0] OFS_IMSK   = 32'h0000_0010;

  // ---------------------------------------------------------------
  // Control/status and interrupt status field positions
  // ---------------------------------------------------------------
  localparam int POS_ENABLE    = 0;
  localparam int POS_TICK_IE   = 1;
  localparam int POS_CLK_SEL   = 2;
  localparam int POS_ZERO_FLAG = 16;
  localparam int POS_ISTS_ZERO = 0;

  // ---------------------------------------------------------------
  // Reset values and bus codes
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] RST_CNT     = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 24'h00_0001;
  localparam logic [IRQ_W-1:0] RST_IRQ     = 1'h0;
  localparam logic [DATA_W-1:0] RST_DATA   = 32'h0000_0000;
  localparam logic             CLK_SEL_CORE = 1'h1;
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]       HTRANS_SEQ    = 2'h3;

  // ---------------------------------------------------------------
  // Whole state of the timer
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              enable;
    logic              tick_irq_enable;
    logic              zero_reached_flag;
    logic [CNT_W-1:0]  reload;
    logic [CNT_W-1:0]  count;
    logic              load_pend;
    logic [IRQ_W-1:0]  irq_sts;
    logic [IRQ_W-1:0]  irq_msk;
    logic              wr_pend;
    logic [IDX_W-1:0]  wr_idx;
    logic [DATA_W-1:0] rdata;
    logic              hready;
    logic              irq;
    logic              tick_pend;
  } ptt_state_t;

  localparam ptt_state_t ST_RST = '{
    enable:            1'h0,
    tick_irq_enable:   1'h0,
    zero_reached_flag: 1'h0,
    reload:            RST_CNT,
    count:             RST_CNT,
    load_pend:         1'h0,
    irq_sts:           RST_IRQ,
    irq_msk:           RST_IRQ,
    wr_pend:           1'h0,
    wr_idx:            3'h0,
    rdata:             RST_DATA,
    hready:            1'h1,
    irq:               1'h0,
    tick_pend:         1'h0
  };

endpackage

// ==== design/ptt_timer.sv ====
// Periodic tick timer with AHB-Lite register slave
//
// Overview of operation
// - No reference clock: clock select reads 1, counter runs on core clock.
// - Tick interrupt enable bit 1 decides if reaching zero pends exception.
// - Enable bit 0 stops counter; setting it loads reload then counts.
// - At zero set flag, pend exception if enabled, reload, keep counting.
// - Reload holds 24-bit start value, copied into count on reload.
// - Reload value 0 gives no flag or exception; only 1-to-0 triggers.
// - Continuous operation with reload N fires every N+1 clocks.
// - Reading count returns the counter value at the access.
// - Any write to count register clears the count to 0.
// - Writing count register also clears the zero-reached flag.
// - Counts down to zero, reloads next edge, then decrements again.
// - Reading control/status clears zero-reached flag at bit 16.
// - While core is halted in debug, counter holds its value.
// - Writing reload zero stops the counter at the next wrap.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
module ptt_timer
  import ptt_pkg::*;
#(
  parameter logic HAS_REF_CLK = 1'b0
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [ptt_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [ptt_pkg::DATA_W-1:0] hwdata,
  output logic      [ptt_pkg::DATA_W-1:0] hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      debug_halt,
  output logic                           tick_pend,
  output logic                           irq
);
  import ptt_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  // only core clock served
  if (HAS_REF_CLK != 1'b0) begin : g_bad_ref
    $error("ptt_timer: reference clock input is not supported");
  end

  // ---------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CTRL   = OFS_CTRL[IDX_W+1:2];
  localparam logic [IDX_W-1:0] IDX_RELOAD = OFS_RELOAD[IDX_W+1:2];
  localparam logic [IDX_W-1:0] IDX_COUNT  = OFS_COUNT[IDX_W+1:2];
  localparam logic [IDX_W-1:0] IDX_ISTS   = OFS_ISTS[IDX_W+1:2];
  localparam logic [IDX_W-1:0] IDX_IMSK   = OFS_IMSK[IDX_W+1:2];
  localparam logic [IDX_W-1:0] IDX_NONE   = 3'h7;

  // Word index of a mapped register, IDX_NONE otherwise
  function automatic logic [IDX_W-1:0] reg_idx(
    input logic [ADDR_W-1:0] a
  );
    logic [IDX_W-1:0] r;
    r = IDX_NONE;
    if ((a[ADDR_W-1:IDX_W+2] == '0) && (a[1:0] == 2'h0)) begin
      r = a[IDX_W+1:2];
      if (r > IDX_IMSK) begin
        r = IDX_NONE;
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State and bus phase decode
  // ---------------------------------------------------------------
  ptt_state_t       q;
  ptt_state_t       d;
  logic             addr_ok;
  logic [IDX_W-1:0] a_idx;
  logic             rd_now;
  logic             wr_ctrl;
  logic             wr_reload;
  logic             wr_count;
  logic             wr_ists;
  logic             wr_imsk;
  logic             run;
  logic             ev;
  logic [DATA_W-1:0] rd_word;

  assign addr_ok   = hsel && hready &&
                     ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));
  assign a_idx     = reg_idx(haddr);
  assign rd_now    = addr_ok && !hwrite;
  assign wr_ctrl   = q.wr_pend && (q.wr_idx == IDX_CTRL);
  assign wr_reload = q.wr_pend && (q.wr_idx == IDX_RELOAD);
  assign wr_count  = q.wr_pend && (q.wr_idx == IDX_COUNT);
  assign wr_ists   = q.wr_pend && (q.wr_idx == IDX_ISTS);
  assign wr_imsk   = q.wr_pend && (q.wr_idx == IDX_IMSK);

  assign run = q.enable && !debug_halt;
  // event only on a 1-to-0 step
  assign ev  = run && !q.load_pend && (q.count == CNT_ONE);

  // ---------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    unique case (a_idx)
      IDX_CTRL: begin
        rd_word[POS_ENABLE]    = q.enable;
        rd_word[POS_TICK_IE]   = q.tick_irq_enable;
        rd_word[POS_CLK_SEL]   = CLK_SEL_CORE;
        rd_word[POS_ZERO_FLAG] = q.zero_reached_flag;
      end
      IDX_COUNT:  rd_word[CNT_W-1:0] = q.count;
      IDX_RELOAD: rd_word[CNT_W-1:0] = q.reload;
      IDX_ISTS:   rd_word[IRQ_W-1:0] = q.irq_sts;
      IDX_IMSK:   rd_word[IRQ_W-1:0] = q.irq_msk;
      default:    rd_word = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d           = q;
    d.hready    = 1'b1;
    d.tick_pend = 1'b0;
    d.rdata     = '0;
    d.wr_pend   = addr_ok && hwrite && (a_idx != IDX_NONE);
    d.wr_idx    = a_idx;

    // unmapped and reserved bits read zero
    if (rd_now) begin
      d.rdata = rd_word;
    end

    // Counter
    if (q.load_pend) begin
      d.count     = q.reload;
      d.load_pend = 1'b0;
    end else if (run) begin
      if (q.count == RST_CNT) begin
        // wrap reloads on the edge after zero
        d.count = q.reload;
      end else begin
        d.count = q.count - CNT_ONE;
      end
    end

    // Register writes
    if (wr_ctrl) begin
      d.enable          = hwdata[POS_ENABLE];
      d.tick_irq_enable = hwdata[POS_TICK_IE];
      if (!q.enable && hwdata[POS_ENABLE]) begin
        d.load_pend = 1'b1;
      end else if (!hwdata[POS_ENABLE]) begin
        d.load_pend = 1'b0;
      end
    end
    if (wr_reload) begin
      d.reload = hwdata[CNT_W-1:0];
    end
    if (wr_count) begin
      d.count             = RST_CNT;
      d.zero_reached_flag = 1'b0;
    end
    if (wr_ists) begin
      d.irq_sts = q.irq_sts & ~hwdata[IRQ_W-1:0];
    end
    if (wr_imsk) begin
      d.irq_msk = hwdata[IRQ_W-1:0];
    end
    if (rd_now && (a_idx == IDX_CTRL)) begin
      d.zero_reached_flag = 1'b0;
    end

    // Events win over clears
    if (ev) begin
      d.zero_reached_flag       = 1'b1;
      d.irq_sts[POS_ISTS_ZERO]  = 1'b1;
      d.tick_pend               = q.tick_irq_enable;
    end
    d.irq = |(d.irq_sts & d.irq_msk);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hrdata    = q.rdata;
  assign hreadyout = q.hready;
  assign hresp     = 1'b0;
  assign tick_pend = q.tick_pend;
  assign irq       = q.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_clk_sel;
    @(posedge hclk) disable iff (!hresetn)
    rd_now && (a_idx == IDX_CTRL) |=> hrdata[POS_CLK_SEL] == 1'b1;
  endproperty
  a_clk_sel: assert property (p_clk_sel)
    else $error("clock select did not read as one");

  property p_pend;
    @(posedge hclk) disable iff (!hresetn)
    ev |=> tick_pend == $past(q.tick_irq_enable);
  endproperty
  a_pend: assert property (p_pend)
    else $error("tick pend does not follow interrupt enable");

  property p_pend_cause;
    @(posedge hclk) disable iff (!hresetn)
    !ev |=> !tick_pend;
  endproperty
  a_pend_cause: assert property (p_pend_cause)
    else $error("tick pend without a count to zero");

  property p_enable_load;
    @(posedge hclk) disable iff (!hresetn)
    $rose(q.enable) |-> q.load_pend ##1 !q.load_pend;
  endproperty
  a_enable_load: assert property (p_enable_load)
    else $error("enable did not load the reload value first");

  property p_event;
    @(posedge hclk) disable iff (!hresetn)
    ev |=> q.zero_reached_flag && q.irq_sts[POS_ISTS_ZERO]
           && (q.count == RST_CNT);
  endproperty
  a_event: assert property (p_event)
    else $error("count to zero did not set the flag");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    run && !q.load_pend && (q.count == RST_CNT) && !q.wr_pend
      |=> q.count == $past(q.reload);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not reload after zero");

  property p_zero_stop;
    @(posedge hclk) disable iff (!hresetn)
    (q.reload == RST_CNT) && (q.count == RST_CNT) && !q.wr_pend
      |=> (q.count == RST_CNT) && !tick_pend;
  endproperty
  a_zero_stop: assert property (p_zero_stop)
    else $error("zero reload restarted the counter");

  property p_read_count;
    @(posedge hclk) disable iff (!hresetn)
    rd_now && (a_idx == IDX_COUNT)
      |=> hrdata == {8'h00, $past(q.count)};
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("count read does not match counter");

  property p_count_clear;
    @(posedge hclk) disable iff (!hresetn)
    wr_count && !ev |=> (q.count == RST_CNT) && !q.zero_reached_flag;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("count write did not clear count and flag");

  property p_read_clear;
    @(posedge hclk) disable iff (!hresetn)
    rd_now && (a_idx == IDX_CTRL) && !ev |=> !q.zero_reached_flag;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear the flag");

  property p_halt;
    @(posedge hclk) disable iff (!hresetn)
    debug_halt && !q.load_pend && !q.wr_pend |=> $stable(q.count);
  endproperty
  a_halt: assert property (p_halt)
    else $error("counter moved while halted");

  property p_reserved;
    @(posedge hclk) disable iff (!hresetn)
    rd_now |=> hrdata[DATA_W-1:CNT_W] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  property p_period;
    @(posedge hclk) disable iff (!hresetn)
    (ev && !q.wr_pend) ##1 (run && !q.wr_pend)
      |=> q.count == $past(q.reload, 2);
  endproperty
  a_period: assert property (p_period)
    else $error("period is not reload plus one");

  property p_reload_wr;
    @(posedge hclk) disable iff (!hresetn)
    wr_reload |=> q.reload == $past(hwdata[CNT_W-1:0]);
  endproperty
  a_reload_wr: assert property (p_reload_wr)
    else $error("reload write did not land");

  property p_flag_hold;
    @(posedge hclk) disable iff (!hresetn)
    q.zero_reached_flag && !wr_count && !(rd_now && (a_idx == IDX_CTRL))
      |=> q.zero_reached_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("zero flag dropped without a clearing access");

  c_tick: cover property (@(posedge hclk) disable iff (!hresetn)
    ev && q.tick_irq_enable);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq));
  c_halt: cover property (@(posedge hclk) disable iff (!hresetn)
    run == 1'b0 && q.enable && q.count != RST_CNT);
  c_clear: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_count && q.count != RST_CNT);
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    run && !q.load_pend && q.count == RST_CNT && q.reload != RST_CNT);

endmodule

// ==== verif/ptt_irq_model.sv ====
// Interrupt controller model logging tick exception requests
module ptt_irq_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        tick_pend,
  output logic      [31:0] pend_cnt,
  output logic      [31:0] gap_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] run_q;

  // ---------------------------------------------------------------
  // Pulse counter and spacing
  // ---------------------------------------------------------------
  // no reference clock offered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_cnt <= 32'h0;
      gap_q    <= 32'h0;
      run_q    <= 32'h0;
    end else if (tick_pend) begin
      pend_cnt <= pend_cnt + 32'h1;
      gap_q    <= run_q + 32'h1;
      run_q    <= 32'h0;
    end else begin
      run_q <= run_q + 32'h1;
    end
  end
endmodule

// ==== verif/periodic_tick_timer_test.sv ====
// Self-checking bench for the periodic tick timer
module periodic_tick_timer_test;
  import ptt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic        hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        debug_halt;
  logic        tick_pend;
  logic        irq;
  logic [31:0] pend_cnt;
  logic [31:0] gap_q;
  logic [31:0] seed;
  logic [31:0] n;
  logic [31:0] c1;
  logic [31:0] c2;
  logic [31:0] p;
  int          n_fail;
  int          checked;
  int          i;

  assign hready = hreadyout;

  ptt_timer #(.HAS_REF_CLK(1'b0)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .debug_halt(debug_halt), .tick_pend(tick_pend),
    .irq(irq)
  );

  ptt_irq_model far (
    .hclk(hclk), .hresetn(hresetn), .tick_pend(tick_pend),
    .pend_cnt(pend_cnt), .gap_q(gap_q)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] ctrl_exp(input logic fl);
    logic [31:0] v;
    v = 32'h0;
    v[POS_CLK_SEL] = CLK_SEL_CORE;
    v[POS_ZERO_FLAG] = fl;
    return v;
  endfunction

  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(nm, e, v);
  endtask

  task automatic wait_pend(input logic [31:0] k);
    int t;
    logic [31:0] s;
    s = pend_cnt;
    t = 0;
    while (pend_cnt !== s + k && t < 4000) begin
      @(posedge hclk);
      t++;
    end
    if (pend_cnt !== s + k) begin
      n_fail++;
      summarize();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    debug_halt = 1'b0;
    seed = 32'had3c7b8b;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(OFS_CTRL, ctrl_exp(1'b0), "ctrl");
    rc(OFS_RELOAD, 32'h0, "reload");
    rc(OFS_COUNT, 32'h0, "count");
    rc(OFS_ISTS, 32'h0, "ists");
    rc(OFS_IMSK, 32'h0, "imsk");
    wr(32'h14, 32'hffff_ffff);
    rc(32'h14, 32'h0, "unmapped");
    wr(OFS_RELOAD, 32'hffff_ffff);
    rc(OFS_RELOAD, 32'h00ff_ffff, "reload");
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      n = (i == 0) ? 32'h1 : {28'h0, seed[3:0]} + 32'h2;
      wr(OFS_RELOAD, n);
      wr(OFS_CTRL, 32'h3);
      wait_pend(32'h2);
      chk("gap", n + 32'h1, gap_q);
      wr(OFS_CTRL, 32'h0);
    end
    rc(OFS_CTRL, ctrl_exp(1'b1), "flag");
    rc(OFS_CTRL, ctrl_exp(1'b0), "flag");
    wr(OFS_RELOAD, 32'h3);
    wr(OFS_CTRL, 32'h1);
    p = pend_cnt;
    repeat (20) @(posedge hclk);
    wr(OFS_CTRL, 32'h0);
    chk("pend", p, pend_cnt);
    seed = lfsr(seed);
    wr(OFS_COUNT, seed);
    rc(OFS_COUNT, 32'h0, "count");
    rc(OFS_CTRL, ctrl_exp(1'b0), "flag");
    chk("pend", p, pend_cnt);
    rc(OFS_ISTS, 32'h1, "ists");
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_IMSK, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_ISTS, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    rc(OFS_ISTS, 32'h0, "ists");
    wr(OFS_RELOAD, 32'd1000);
    wr(OFS_CTRL, 32'h3);
    // Let the enabling load settle before sampling
    repeat (2) @(posedge hclk);
    bus(1'b0, OFS_COUNT, 32'h0, c1);
    bus(1'b0, OFS_COUNT, 32'h0, c2);
    chk("cdelta", 32'h2, c1 - c2);
    debug_halt <= 1'b1;
    bus(1'b0, OFS_COUNT, 32'h0, c1);
    bus(1'b0, OFS_COUNT, 32'h0, c2);
    debug_halt <= 1'b0;
    chk("halt", c1, c2);
    wr(OFS_RELOAD, 32'h0);
    wait_pend(32'h1);
    p = pend_cnt;
    repeat (50) @(posedge hclk);
    chk("pend", p, pend_cnt);
    rc(OFS_COUNT, 32'h0, "count");
    summarize();
  end
endmodule
